/* hdl/tmc_pkg.sv */
// Constants, types and timing for the totaliser menu controller.
// Assumes a single 250 MHz clock shared by all users of this package.
package tmc_pkg;
  // Clock and times
  localparam longint CLK_HZ      = 250_000_000;
  localparam longint PIN_TO_S    = 10;
  localparam longint STORE_MS    = 2000;
  localparam longint DEB_MS      = 10;
  localparam longint PIN_TO_CYC  = PIN_TO_S * CLK_HZ;
  localparam longint STORE_CYC   = STORE_MS * CLK_HZ / 1000;
  localparam longint DEB_CYC     = DEB_MS * CLK_HZ / 1000;
  // Codes and limits
  localparam logic [15:0] PIN_DEFAULT   = 16'h0000;
  localparam logic [15:0] COND_PASSWORD = 16'h5123;
  localparam logic [1:0]  STEP_RST      = 2'h0;
  localparam logic [2:0]  RDP_MAX       = 3'h4;
  localparam logic [2:0]  TDP_MAX       = 3'h7;
  localparam logic [2:0]  TDP_MAX_SWAP  = 3'h5;
  localparam logic [3:0]  DIG_MAX       = 4'h9;
  localparam logic [3:0]  TOP_MAX       = 4'h2;
  localparam logic [15:0] REF_ZERO      = 16'h0000;
  localparam logic [15:0] REF_SPAN      = 16'hffff;
  // Menu items
  localparam logic [2:0] MI_ROOT = 3'h0;
  localparam logic [2:0] MI_RATE_STEP_SIZE = 3'h1;
  localparam logic [2:0] MI_DP   = 3'h2;
  localparam logic [2:0] MI_CAL  = 3'h3;
  localparam logic [2:0] MI_SET  = 3'h4;
  localparam logic [2:0] MI_COND = 3'h5;
  // Register map
  localparam logic [3:0] A_PIN  = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_ZERO = 4'h8;
  localparam logic [3:0] A_SPAN = 4'hc;
  localparam logic [1:0] RESP_OK     = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_DISP, ST_CODE, ST_PIN, ST_MENU, ST_ROOT, ST_RATE_STEP_SIZE, ST_DP, ST_ZPR,
    ST_ZED, ST_SPR, ST_SED, ST_STORE, ST_CPW, ST_COND, ST_FREQ
  } tmc_state_t;

  typedef struct packed {
    logic p;
    logic e;
    logic up;
    logic dn;
  } tmc_keys_t;

  typedef struct packed {
    tmc_state_t  mode;
    logic [19:0] value;
    logic [2:0]  flash;
    logic        both_on;
    logic        store_busy;
  } tmc_disp_t;

  typedef struct packed {
    logic       root_on;
    logic [1:0] step;
    logic [2:0] rate_dp;
    logic [2:0] total_dp;
    logic       swap;
    logic       filt_60hz;
  } tmc_cfg_t;
endpackage

/* hdl/tmc_menu.sv */
// Push-button menu and calibration controller with AXI4-Lite status port.
// Assumes raw keys are active high and synchronous-safe via local sync.
`timescale 1ns/1ps
`default_nettype none
module tmc_menu
  import tmc_pkg::*;
#(
  parameter logic [31:0] PIN_TO   = 32'(PIN_TO_CYC),
  parameter logic [31:0] STORE_TO = 32'(STORE_CYC),
  parameter logic [31:0] DEB_TO   = 32'(DEB_CYC)
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Front panel and loop input
  input  wire tmc_keys_t   keys_raw,
  input  wire logic [15:0] loop_in,
  // Displays and settings
  output tmc_disp_t        disp,
  output tmc_cfg_t         cfg,
  output logic [15:0]      flow_lin,
  output logic             totalise_en,
  output logic [15:0]      zero_in,
  output logic [15:0]      span_in,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  function automatic logic [15:0] isqrt(input logic [31:0] v);
    logic [15:0] r;
    logic [31:0] t;
    r = '0;
    for (int i = 15; i >= 0; i--) begin
      t = {16'h0000, r | (16'h0001 << i)};
      if (t * t <= v) begin
        r = r | (16'h0001 << i);
      end
    end
    return r;
  endfunction

  function automatic logic [19:0] dstep(input logic [19:0] v, input logic [1:0] c,
                                        input logic up, input logic roll);
    logic [3:0]  d;
    logic [3:0]  t;
    logic [19:0] r;
    r = v;
    d = v[c*4 +: 4];
    t = v[19:16];
    if (up) begin
      if (d == DIG_MAX) begin
        d = 4'h0;
        if (roll && c == 2'h3) begin
          t = (t == TOP_MAX) ? 4'h0 : t + 4'h1;
        end
      end else begin
        d = d + 4'h1;
      end
    end else begin
      if (d == 4'h0) begin
        d = DIG_MAX;
        if (roll && c == 2'h3) begin
          t = (t == 4'h0) ? TOP_MAX : t - 4'h1;
        end
      end else begin
        d = d - 4'h1;
      end
    end
    r[c*4 +: 4] = d;
    r[19:16] = t;
    return r;
  endfunction

  // Key conditioning
  logic [3:0]  ks1_reg, ks2_reg, kprev_reg, kdeb_reg, kdeb_d_reg;
  logic [31:0] deb_cnt_reg;
  wire         deb_tick = (deb_cnt_reg == DEB_TO - 32'h1);
  wire  [3:0]  kpr      = kdeb_reg & ~kdeb_d_reg;
  wire         p_p      = kpr[3] & ~kdeb_reg[2];
  wire         e_p      = kpr[2] & ~kdeb_reg[3];
  wire         up_p     = kpr[1] & ~kdeb_reg[0];
  wire         dn_p     = kpr[0] & ~kdeb_reg[1];
  wire         chord    = kdeb_reg[1] & kdeb_reg[0] & (kpr[1] | kpr[0]);
  wire         menu_go  = kdeb_reg[3] & kdeb_reg[2] & (kpr[3] | kpr[2]);
  wire         any_p    = |kpr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ks1_reg     <= 4'h0;
      ks2_reg     <= 4'h0;
      kprev_reg   <= 4'h0;
      kdeb_reg    <= 4'h0;
      kdeb_d_reg  <= 4'h0;
      deb_cnt_reg <= 32'h0;
    end else begin
      ks1_reg     <= keys_raw;
      ks2_reg     <= ks1_reg;
      kdeb_d_reg  <= kdeb_reg;
      deb_cnt_reg <= deb_tick ? 32'h0 : deb_cnt_reg + 32'h1;
      if (deb_tick) begin
        kprev_reg <= ks2_reg;
        if (ks2_reg == kprev_reg) begin
          kdeb_reg <= ks2_reg;
        end
      end
    end
  end

  // Menu state
  tmc_state_t  st_reg, st_next;
  logic [2:0]  mi_reg, mi_next, rdp_reg, rdp_next, tdp_reg, tdp_next;
  logic [1:0]  step_reg, step_next, cur_reg, cur_next;
  logic        root_reg, root_next, dsel_reg, dsel_next, swap_reg, swap_next;
  logic        f60_reg, f60_next, iref_reg, iref_next, sret_reg, sret_next;
  logic [19:0] ed_reg, ed_next, zero_reg, zero_next, span_reg, span_next;
  logic [15:0] zin_next, sin_next, pin_reg;
  logic [31:0] tmr_reg, tmr_next;
  wire  [2:0]  tmax   = swap_reg ? TDP_MAX_SWAP : TDP_MAX;
  wire  [2:0]  dp_act = dsel_reg ? rdp_reg : tdp_reg;
  wire  [2:0]  dp_max = dsel_reg ? RDP_MAX : tmax;
  wire  [2:0]  dp_up  = (dp_act >= dp_max) ? 3'h0 : dp_act + 3'h1;
  wire  [2:0]  dp_dn  = (dp_act == 3'h0) ? dp_max : dp_act - 3'h1;
  wire  [2:0]  dp_new = up_p ? dp_up : dp_dn;
  wire  [15:0] cap_z  = iref_reg ? REF_ZERO : loop_in;
  wire  [15:0] cap_s  = iref_reg ? REF_SPAN : loop_in;
  wire         tmr_end = (tmr_reg == 32'h1);

  always_comb begin
    st_next   = st_reg;
    mi_next   = mi_reg;
    root_next = root_reg;
    step_next = step_reg;
    rdp_next  = rdp_reg;
    tdp_next  = tdp_reg;
    dsel_next = dsel_reg;
    swap_next = swap_reg;
    f60_next  = f60_reg;
    ed_next   = ed_reg;
    cur_next  = cur_reg;
    zero_next = zero_reg;
    span_next = span_reg;
    zin_next  = zero_in;
    sin_next  = span_in;
    iref_next = iref_reg;
    sret_next = sret_reg;
    tmr_next  = (tmr_reg != 32'h0) ? tmr_reg - 32'h1 : 32'h0;
    case (st_reg)
      ST_DISP: begin
        if (menu_go) begin
          st_next = (pin_reg == PIN_DEFAULT) ? ST_MENU : ST_CODE;
          tmr_next = PIN_TO;
          mi_next = MI_ROOT;
        end
      end
      ST_CODE, ST_PIN: begin
        if (any_p) begin
          tmr_next = PIN_TO;
        end
        if (tmr_end && !any_p) begin
          st_next = ST_DISP;
        end else if (st_reg == ST_CODE) begin
          if (p_p) begin
            st_next = ST_PIN;
            ed_next = 20'h0;
            cur_next = 2'h0;
          end
        end else if (up_p || dn_p) begin
          ed_next = dstep(ed_reg, cur_reg, up_p, 1'b0);
        end else if (p_p) begin
          cur_next = cur_reg + 2'h1;
        end else if (e_p && ed_reg[15:0] == pin_reg) begin
          st_next = ST_MENU;
        end
      end
      ST_MENU: begin
        if (up_p) begin
          mi_next = (mi_reg == MI_COND) ? MI_ROOT : mi_reg + 3'h1;
        end else if (dn_p) begin
          mi_next = (mi_reg == MI_ROOT) ? MI_COND : mi_reg - 3'h1;
        end else if (e_p) begin
          st_next = ST_DISP;
        end else if (p_p) begin
          ed_next = 20'h0;
          cur_next = 2'h0;
          dsel_next = 1'b0;
          iref_next = (mi_reg == MI_SET);
          case (mi_reg)
            MI_ROOT: st_next = ST_ROOT;
            MI_RATE_STEP_SIZE: st_next = ST_RATE_STEP_SIZE;
            MI_DP:   st_next = ST_DP;
            MI_CAL:  st_next = ST_ZPR;
            MI_SET:  st_next = ST_ZPR;
            default: st_next = ST_CPW;
          endcase
        end
      end
      ST_ROOT: begin
        if (up_p || dn_p) begin
          root_next = !root_reg;
        end else if (e_p) begin
          st_next = ST_MENU;
        end
      end
      ST_RATE_STEP_SIZE: begin
        if (up_p) begin
          step_next = step_reg + 2'h1;
        end else if (dn_p) begin
          step_next = step_reg - 2'h1;
        end else if (e_p) begin
          st_next = ST_MENU;
        end
      end
      ST_DP: begin
        if (chord) begin
          swap_next = !swap_reg;
          if (!swap_reg && tdp_reg > TDP_MAX_SWAP) begin
            tdp_next = TDP_MAX_SWAP;
          end
        end else if (up_p || dn_p) begin
          if (dsel_reg) begin
            rdp_next = dp_new;
          end else begin
            tdp_next = dp_new;
          end
        end else if (p_p) begin
          dsel_next = !dsel_reg;
        end else if (e_p) begin
          st_next = ST_MENU;
        end
      end
      ST_ZPR, ST_SPR: begin
        if (p_p) begin
          cur_next = 2'h0;
          if (st_reg == ST_ZPR) begin
            zin_next = cap_z;
            ed_next = zero_reg;
            st_next = ST_ZED;
          end else begin
            sin_next = cap_s;
            ed_next = span_reg;
            st_next = ST_SED;
          end
        end else if (up_p) begin
          st_next = ST_SPR;
        end else if (dn_p) begin
          st_next = ST_ZPR;
        end else if (e_p) begin
          st_next = ST_MENU;
        end
      end
      ST_ZED, ST_SED: begin
        if (up_p || dn_p) begin
          ed_next = dstep(ed_reg, cur_reg, up_p, 1'b1);
        end else if (p_p) begin
          cur_next = cur_reg + 2'h1;
        end else if (e_p) begin
          sret_next = (st_reg == ST_SED);
          if (st_reg == ST_ZED) begin
            zero_next = ed_reg;
          end else begin
            span_next = ed_reg;
          end
          if (iref_reg) begin
            st_next = (st_reg == ST_ZED) ? ST_ZPR : ST_SPR;
          end else begin
            st_next = ST_STORE;
            tmr_next = STORE_TO;
          end
        end
      end
      ST_STORE: begin
        if (tmr_end) begin
          st_next = sret_reg ? ST_SPR : ST_ZPR;
        end
      end
      ST_CPW: begin
        if (up_p || dn_p) begin
          ed_next = dstep(ed_reg, cur_reg, up_p, 1'b0);
        end else if (p_p) begin
          cur_next = cur_reg + 2'h1;
        end else if (e_p) begin
          st_next = (ed_reg[15:0] == COND_PASSWORD) ? ST_COND : ST_MENU;
        end
      end
      ST_COND: begin
        if (p_p) begin
          st_next = ST_FREQ;
        end else if (e_p) begin
          st_next = ST_MENU;
        end
      end
      ST_FREQ: begin
        if (up_p || dn_p) begin
          f60_next = !f60_reg;
        end else if (e_p) begin
          st_next = ST_COND;
        end
      end
      default: st_next = ST_DISP;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_DISP;
      {mi_reg, rdp_reg, tdp_reg, step_reg, cur_reg} <= 13'h0;
      {root_reg, dsel_reg, swap_reg, f60_reg, iref_reg, sret_reg} <= 6'h0;
      {ed_reg, zero_reg, span_reg, zero_in, span_in} <= 92'h0;
      tmr_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      {mi_reg, rdp_reg, tdp_reg, step_reg, cur_reg} <=
        {mi_next, rdp_next, tdp_next, step_next, cur_next};
      {root_reg, dsel_reg, swap_reg, f60_reg, iref_reg, sret_reg} <=
        {root_next, dsel_next, swap_next, f60_next, iref_next, sret_next};
      {ed_reg, zero_reg, span_reg, zero_in, span_in} <=
        {ed_next, zero_next, span_next, zin_next, sin_next};
      tmr_reg <= tmr_next;
    end
  end

  // Outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp        <= '0;
      flow_lin    <= 16'h0;
      totalise_en <= 1'b0;
    end else begin
      disp.mode       <= st_next;
      disp.value      <= ed_next;
      disp.flash      <= (st_next == ST_DP) ? (dsel_next ? rdp_next : tdp_next)
                                            : {1'b0, cur_next};
      disp.both_on    <= (st_next == ST_DP);
      disp.store_busy <= (st_next == ST_STORE);
      flow_lin    <= root_reg ? isqrt({loop_in, 16'h0}) : loop_in;
      totalise_en <= (st_next == ST_DISP);
    end
  end
  assign cfg = '{root_on: root_reg, step: step_reg, rate_dp: rdp_reg,
                 total_dp: tdp_reg, swap: swap_reg, filt_60hz: f60_reg};

  // AXI4-Lite slave
  logic        awh_reg, wh_reg;
  logic [3:0]  awa_reg, wstb_reg;
  logic [31:0] wd_reg;
  wire         wr_go  = awh_reg && wh_reg && !s_axi_bvalid;
  wire         wr_ok  = (awa_reg == A_PIN);
  wire         rd_ok  = (s_axi_araddr == A_PIN) || (s_axi_araddr == A_STAT) ||
                        (s_axi_araddr == A_ZERO) || (s_axi_araddr == A_SPAN);
  wire  [31:0] rd_word = (s_axi_araddr == A_PIN)  ? {16'h0, pin_reg} :
                         (s_axi_araddr == A_STAT) ? {17'h0, st_reg, cfg} :
                         (s_axi_araddr == A_ZERO) ? {12'h0, zero_reg} :
                         (s_axi_araddr == A_SPAN) ? {12'h0, span_reg} : 32'h0;
  assign s_axi_awready = !awh_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wh_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awh_reg, wh_reg, awa_reg, wstb_reg, wd_reg} <= 42'h0;
      {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp} <= 6'h0;
      s_axi_rdata <= 32'h0;
      pin_reg <= PIN_DEFAULT;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awh_reg <= 1'b1;
        awa_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_reg   <= 1'b1;
        wd_reg   <= s_axi_wdata;
        wstb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        awh_reg      <= 1'b0;
        wh_reg       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OK : RESP_SLVERR;
        for (int b = 0; b < 2; b++) begin
          if (wr_ok && wstb_reg[b]) begin
            pin_reg[8*b +: 8] <= wd_reg[8*b +: 8];
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence zero_exit_s;
    st_reg == ST_ZED && e_p && !iref_reg;
  endsequence
  pin_skip_a: assert property (st_reg == ST_DISP && menu_go && pin_reg == PIN_DEFAULT
    |=> st_reg == ST_MENU) else $error("zero PIN did not open menu");
  root_toggle_a: assert property (st_reg == ST_ROOT && up_p
    |=> root_reg != $past(root_reg)) else $error("root setting did not toggle");
  half_flow_a: assert property (root_reg && loop_in == 16'h4000
    |=> flow_lin == 16'h8000) else $error("half flow not at quarter input");
  step_move_a: assert property (st_reg == ST_RATE_STEP_SIZE && dn_p
    |=> step_reg == $past(step_reg) - 2'h1) else $error("step did not move");
  dp_range_a: assert property (rdp_reg <= 3'h4 && (!swap_reg || tdp_reg <= 3'h5))
    else $error("point position out of range");
  swap_a: assert property (st_reg == ST_DP && chord
    |=> swap_reg != $past(swap_reg) ##1 disp.both_on) else $error("swap not applied");
  store_seq_a: assert property (zero_exit_s |=> st_reg == ST_STORE ##1 disp.store_busy
    ) else $error("zero commit did not store");
  pw_gate_a: assert property (st_reg == ST_CPW && e_p && ed_reg[15:0] != COND_PASSWORD
    |=> st_reg != ST_COND) else $error("tuning opened on wrong password");
  halt_tot_a: assert property (st_reg != ST_DISP |-> !totalise_en)
    else $error("totalisation ran in menu");
  pin_to_a: assert property ((st_reg == ST_PIN || st_reg == ST_CODE) && tmr_end && !any_p
    |=> st_reg == ST_DISP) else $error("PIN entry did not time out");
endmodule
`default_nettype wire

/* testbench/tmc_operator.sv */
// Operator model that presses the front panel buttons.
// Assumes the controller samples keys on aclk and debounces them itself.
`timescale 1ns/1ps
`default_nettype none
module tmc_operator
  import tmc_pkg::*;
#(
  parameter int HOLD = 24,
  parameter int GAP  = 24
) (
  // Clock
  input  wire logic      aclk,
  // Buttons
  output var tmc_keys_t  keys_raw
);
  initial keys_raw = '0;

  // Keys of a chord go down on one edge
  task automatic press(input tmc_keys_t k);
    keys_raw <= k;
    repeat (HOLD) @(posedge aclk);
    // Released buttons fall to open level
    keys_raw <= '0;
    repeat (GAP) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_totaliser_menu_calibration.sv */
// Self-checking bench for the totaliser menu controller.
// Assumes tmc_pkg, tmc_menu and tmc_operator are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_totaliser_menu_calibration
  import tmc_pkg::*;
;
  localparam tmc_keys_t K_P  = 4'h8;
  localparam tmc_keys_t K_E  = 4'h4;
  localparam tmc_keys_t K_UP = 4'h2;
  localparam tmc_keys_t K_DN = 4'h1;
  localparam tmc_keys_t K_PE = 4'hc;
  localparam tmc_keys_t K_CH = 4'h3;
  logic        aclk;
  logic        aresetn;
  wire         tmc_keys_t keys_raw;
  logic [15:0] loop_in;
  tmc_disp_t   disp;
  tmc_cfg_t    cfg;
  logic [15:0] flow_lin;
  logic        totalise_en;
  logic [15:0] zero_in;
  logic [15:0] span_in;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          bad_count;
  int          n_checks;
  int          i;
  int          pw [4] = '{3, 2, 1, 5};

  tmc_menu #(.PIN_TO(32'hc8), .STORE_TO(32'h64), .DEB_TO(32'h4)) tmc_menu_i (
    .aclk(aclk), .aresetn(aresetn), .keys_raw(keys_raw), .loop_in(loop_in),
    .disp(disp), .cfg(cfg), .flow_lin(flow_lin), .totalise_en(totalise_en),
    .zero_in(zero_in), .span_in(span_in),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  tmc_operator #(.HOLD(24), .GAP(24)) tmc_operator_i (.aclk(aclk), .keys_raw(keys_raw));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    chk(bvalid, 1'b1);
    chk(bresp, er);
    if (bvalid !== 1'b1) tally_and_finish();
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, ed);
    chk(rresp, er);
    if (rvalid !== 1'b1) tally_and_finish();
    @(posedge aclk);
  endtask

  task automatic key(input tmc_keys_t k, input tmc_state_t m);
    tmc_operator_i.press(k);
    chk(disp.mode, m);
  endtask

  task automatic wait_mode(input tmc_state_t m, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (disp.mode !== m && n < lim);
    chk(disp.mode, m);
    if (disp.mode !== m) tally_and_finish();
  endtask

  initial begin
    aresetn = 1'b0;
    loop_in = 16'h4000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(flow_lin, 32'h4000);
    axi_rd(4'h0, 32'h0, RESP_OK);
    axi_rd(4'h2, 32'h0, RESP_SLVERR);
    axi_wr(4'h4, 32'h1, RESP_SLVERR);
    chk(totalise_en, 1'b1);
    key(K_PE, ST_MENU);
    chk(totalise_en, 1'b0);
    key(K_P, ST_ROOT);
    key(K_UP, ST_ROOT);
    chk(cfg.root_on, 1'b1);
    key(K_E, ST_MENU);
    chk(flow_lin, 32'h8000);
    key(K_UP, ST_MENU);
    key(K_P, ST_RATE_STEP_SIZE);
    for (i = 1; i <= 4; i++) begin
      key(K_UP, ST_RATE_STEP_SIZE);
      chk(cfg.step, i % 4);
    end
    key(K_DN, ST_RATE_STEP_SIZE);
    chk(cfg.step, 32'h3);
    key(K_E, ST_MENU);
    key(K_UP, ST_MENU);
    key(K_P, ST_DP);
    chk(disp.both_on, 1'b1);
    key(K_UP, ST_DP);
    chk(cfg.total_dp, 32'h1);
    chk(disp.flash, 32'h1);
    key(K_P, ST_DP);
    key(K_DN, ST_DP);
    chk(cfg.rate_dp, 32'h4);
    key(K_CH, ST_DP);
    chk(cfg.swap, 1'b1);
    key(K_E, ST_MENU);
    key(K_UP, ST_MENU);
    key(K_P, ST_ZPR);
    loop_in <= 16'h1234;
    key(K_P, ST_ZED);
    chk(zero_in, 32'h1234);
    repeat (3) key(K_P, ST_ZED);
    key(K_DN, ST_ZED);
    chk(disp.value, 32'h29000);
    key(K_E, ST_STORE);
    chk(disp.store_busy, 1'b1);
    wait_mode(ST_ZPR, 200);
    axi_rd(4'h8, 32'h29000, RESP_OK);
    key(K_UP, ST_SPR);
    loop_in <= 16'habcd;
    key(K_P, ST_SED);
    chk(span_in, 32'habcd);
    key(K_E, ST_STORE);
    wait_mode(ST_SPR, 200);
    key(K_E, ST_MENU);
    key(K_UP, ST_MENU);
    key(K_P, ST_ZPR);
    key(K_P, ST_ZED);
    chk(zero_in, REF_ZERO);
    key(K_E, ST_ZPR);
    key(K_UP, ST_SPR);
    key(K_P, ST_SED);
    chk(span_in, REF_SPAN);
    key(K_E, ST_SPR);
    key(K_E, ST_MENU);
    key(K_UP, ST_MENU);
    key(K_P, ST_CPW);
    key(K_E, ST_MENU);
    key(K_P, ST_CPW);
    foreach (pw[j]) begin
      repeat (pw[j]) key(K_UP, ST_CPW);
      key(K_P, ST_CPW);
    end
    key(K_E, ST_COND);
    key(K_P, ST_FREQ);
    key(K_UP, ST_FREQ);
    chk(cfg.filt_60hz, 1'b1);
    key(K_E, ST_COND);
    key(K_E, ST_MENU);
    key(K_E, ST_DISP);
    chk(totalise_en, 1'b1);
    axi_wr(4'h0, 32'h1234, RESP_OK);
    axi_rd(4'h0, 32'h1234, RESP_OK);
    wstrb <= 4'h1;
    axi_wr(4'h0, 32'hff99, RESP_OK);
    axi_rd(4'h0, 32'h1299, RESP_OK);
    key(K_PE, ST_CODE);
    repeat (100) @(posedge aclk);
    chk(disp.mode, ST_CODE);
    wait_mode(ST_DISP, 300);
    tally_and_finish();
  end
endmodule
`default_nettype wire
